/* sfe_pkg.sv */
`default_nettype none
// ============================================================
// Shared constants and types of the serial flash erase sequencer
package sfe_pkg;

  // ==========================================================
  // Command encoding
  localparam logic [7:0]  SFE_OP_PAGE_ERASE   = 8'h81;
  localparam logic [7:0]  SFE_OP_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0]  SFE_OP_SECTOR_ERASE = 8'h7C;
  localparam logic [31:0] SFE_CHIP_ERASE_SEQ  = 32'hC794_809A;
  localparam logic [5:0]  SFE_CMD_BITS        = 6'h20;

  // ==========================================================
  // Address field positions inside the three address bytes
  localparam int SFE_PAGE_LSB_264 = 9;
  localparam int SFE_PAGE_LSB_256 = 8;
  localparam int SFE_PAGE_W       = 11;
  localparam logic [3:0] SFE_SECTOR_SLOTS = 4'h9;

  // ==========================================================
  // Array layout in pages
  localparam logic [11:0] SFE_PAGE_COUNT_ONE  = 12'h001;
  localparam logic [11:0] SFE_BLOCK_PAGES     = 12'h008;
  localparam logic [11:0] SFE_SMALL_0B_PAGES  = 12'h0F8;
  localparam logic [11:0] SFE_SECTOR_PAGES    = 12'h100;
  localparam logic [10:0] SFE_SMALL_0B_FIRST  = 11'h008;

  // ==========================================================
  // Timing: erase times in microseconds, clock period in ns
  localparam int SFE_CLK_PERIOD_NS        = 50;
  localparam int SFE_CLK_PER_US           = 1000 / SFE_CLK_PERIOD_NS;
  localparam int SFE_PAGE_ERASE_TIME_US   = 32'h0000_61A8;
  localparam int SFE_BLOCK_ERASE_TIME_US  = 32'h0001_1170;
  localparam int SFE_SECTOR_ERASE_TIME_US = 32'h001E_8480;
  localparam int SFE_CHIP_ERASE_TIME_US   = 32'h007A_1200;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SFE_ST_IDLE,
    SFE_ST_CHIP_WALK,
    SFE_ST_WAIT
  } sfe_state_e;

  typedef struct packed {
    logic [10:0] first_page;
    logic [11:0] page_count;
  } sfe_req_s;

endpackage : sfe_pkg
`default_nettype wire

/* sfe_erase_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module sfe_erase_seq #(
  parameter int PAGE_ERASE_CYCLES   = sfe_pkg::SFE_PAGE_ERASE_TIME_US * sfe_pkg::SFE_CLK_PER_US,
  parameter int BLOCK_ERASE_CYCLES  = sfe_pkg::SFE_BLOCK_ERASE_TIME_US * sfe_pkg::SFE_CLK_PER_US,
  parameter int SECTOR_ERASE_CYCLES = sfe_pkg::SFE_SECTOR_ERASE_TIME_US * sfe_pkg::SFE_CLK_PER_US,
  parameter int CHIP_ERASE_CYCLES   = sfe_pkg::SFE_CHIP_ERASE_TIME_US * sfe_pkg::SFE_CLK_PER_US
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  input  wire logic             sck_in,
  input  wire logic             cs_b_in,
  input  wire logic             si_in,
  input  wire logic             wp_b_in,
  input  wire logic             page_256_in,
  input  wire logic [8:0]       sector_protect_in,
  input  wire logic [8:0]       sector_lock_in,
  input  wire logic             erase_fail_in,
  output var  sfe_pkg::sfe_req_s erase_req_out,
  output var  logic             erase_go_out,
  output var  logic             busy_out,
  output var  logic             erase_program_error_flag_out,
  output var  logic             protect_active_out
);
  import sfe_pkg::*;
  // ==========================================================
  // Pin synchronisers: bit 0 sck, 1 cs_b, 2 si, 3 wp_b
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;

  // Third stage only feeds edge detection, never the first stage
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= 4'hA;
      sync2_q <= 4'hA;
      sync3_q <= 4'hA;
    end else begin
      sync1_q <= {wp_b_in, si_in, cs_b_in, sck_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic sck_rise;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;

  // Edges of the slow link clock and chip select
  assign sck_rise = sync2_q[0] & ~sync3_q[0];
  assign cs_fall  = ~sync2_q[1] & sync3_q[1];
  assign cs_rise  = sync2_q[1] & ~sync3_q[1];
  assign cs_low   = ~sync2_q[1];

  // ==========================================================
  // Serial receive: first 32 bits of a frame, rest dropped
  logic [31:0] shift_q;
  logic [31:0] shift_d;
  logic [5:0]  nbits_q;
  logic [5:0]  nbits_d;

  always_comb begin
    shift_d = shift_q;
    nbits_d = nbits_q;
    if (cs_fall) begin
      shift_d = 32'h0000_0000;
      nbits_d = 6'h00;
    end else if (cs_low && sck_rise && nbits_q < SFE_CMD_BITS) begin
      shift_d = {shift_q[30:0], sync2_q[2]};
      nbits_d = nbits_q + 6'h01;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shift_q <= 32'h0000_0000;
      nbits_q <= 6'h00;
    end else begin
      shift_q <= shift_d;
      nbits_q <= nbits_d;
    end
  end

  // ==========================================================
  // Command decode at chip select rise
  logic [7:0]  dec_op;
  logic [23:0] dec_addr;
  logic [10:0] dec_page;
  logic        dec_full;
  logic        dec_chip;
  logic        dec_page_op;
  logic        dec_block_op;
  logic        dec_sector_op;
  sfe_req_s    dec_req;

  assign dec_op   = shift_q[31:24];
  assign dec_addr = shift_q[23:0];
  // Binary mode page is logical address 18:8 of the 19-bit address
  assign dec_page = page_256_in ? dec_addr[SFE_PAGE_LSB_256 +: SFE_PAGE_W]
                                : dec_addr[SFE_PAGE_LSB_264 +: SFE_PAGE_W];
  // Anything short of the full opcode and address is thrown away
  assign dec_full      = (nbits_q == SFE_CMD_BITS);
  assign dec_chip      = dec_full && (shift_q == SFE_CHIP_ERASE_SEQ);
  assign dec_page_op   = dec_full && (dec_op == SFE_OP_PAGE_ERASE);
  assign dec_block_op  = dec_full && (dec_op == SFE_OP_BLOCK_ERASE);
  assign dec_sector_op = dec_full && (dec_op == SFE_OP_SECTOR_ERASE);

  // Sector slot: 0 is 0a, 1 is 0b, 2..8 are sectors 1..7
  function automatic sfe_req_s sector_req(input logic [3:0] slot);
    sfe_req_s r;
    r.first_page = 11'h000;
    r.page_count = SFE_SECTOR_PAGES;
    if (slot == 4'h0) begin
      r.page_count = SFE_BLOCK_PAGES;
    end else if (slot == 4'h1) begin
      r.first_page = SFE_SMALL_0B_FIRST;
      r.page_count = SFE_SMALL_0B_PAGES;
    end else begin
      r.first_page = {3'(slot - 4'h1), 8'h00};
    end
    return r;
  endfunction : sector_req
  logic [3:0] dec_slot;
  // Any page inside a sector picks it; top three bits zero means small sector
  always_comb begin
    if (dec_page[10:8] != 3'h0) begin
      dec_slot = {1'b0, dec_page[10:8]} + 4'h1;
    end else if (dec_page[7:3] != 5'h00) begin
      dec_slot = 4'h1;
    end else begin
      dec_slot = 4'h0;
    end
  end

  // Request shape for single-shot erases
  always_comb begin
    dec_req.first_page = dec_page;
    dec_req.page_count = SFE_PAGE_COUNT_ONE;
    if (dec_block_op) begin
      dec_req.first_page = {dec_page[10:3], 3'h0};
      dec_req.page_count = SFE_BLOCK_PAGES;
    end else if (dec_sector_op) begin
      dec_req = sector_req(dec_slot);
    end
  end

  logic launch;
  logic launch_any;
  // Frames arriving while busy are ignored, nothing is queued
  assign launch_any = cs_rise && !busy_out;
  assign launch     = launch_any && (dec_page_op || dec_block_op || dec_sector_op);

  // ==========================================================
  // Erase engine
  sfe_state_e  state_q;
  sfe_state_e  state_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;
  logic [3:0]  step_q;
  logic [3:0]  step_d;
  sfe_req_s    req_q;
  sfe_req_s    req_d;
  logic        go_q;
  logic        go_d;
  logic        busy_q;
  logic        busy_d;
  logic        epe_q;
  logic        epe_d;
  logic [8:0]  guard;

  assign guard = sector_protect_in | sector_lock_in;
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    step_d  = step_q;
    req_d   = req_q;
    go_d    = 1'b0;
    // A failure seen while busy is sticky until the next erase starts
    epe_d   = epe_q | (busy_q & erase_fail_in);
    case (state_q)
      SFE_ST_IDLE: begin
        if (launch) begin
          req_d   = dec_req;
          go_d    = 1'b1;
          epe_d   = 1'b0;
          state_d = SFE_ST_WAIT;
          if (dec_page_op) begin
            timer_d = 32'(PAGE_ERASE_CYCLES - 1);
          end else if (dec_block_op) begin
            timer_d = 32'(BLOCK_ERASE_CYCLES - 1);
          end else begin
            timer_d = 32'(SECTOR_ERASE_CYCLES - 1);
          end
        end else if (launch_any && dec_chip) begin
          epe_d   = 1'b0;
          step_d  = 4'h0;
          state_d = SFE_ST_CHIP_WALK;
        end
      end
      SFE_ST_CHIP_WALK: begin
        // One request per open sector; guarded ones are skipped
        if (!guard[step_q]) begin
          req_d = sector_req(step_q);
          go_d  = 1'b1;
        end
        step_d = step_q + 4'h1;
        if (step_q == SFE_SECTOR_SLOTS - 4'h1) begin
          timer_d = 32'(CHIP_ERASE_CYCLES - 1);
          state_d = SFE_ST_WAIT;
        end
      end
      SFE_ST_WAIT: begin
        if (timer_q == 32'h0000_0000) begin
          state_d = SFE_ST_IDLE;
        end else begin
          timer_d = timer_q - 32'h0000_0001;
        end
      end
      default: begin
        state_d = SFE_ST_IDLE;
      end
    endcase
    busy_d = (state_d != SFE_ST_IDLE);
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= SFE_ST_IDLE;
      timer_q <= 32'h0000_0000;
      step_q  <= 4'h0;
      req_q   <= '0;
      go_q    <= 1'b0;
      busy_q  <= 1'b0;
      epe_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      step_q  <= step_d;
      req_q   <= req_d;
      go_q    <= go_d;
      busy_q  <= busy_d;
      epe_q   <= epe_d;
    end
  end

  // ==========================================================
  // Write protect: follows the pin only while no erase runs
  logic prot_q;
  logic prot_d;

  always_comb begin
    prot_d = busy_q ? prot_q : ~sync2_q[3];
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prot_q <= 1'b0;
    end else begin
      prot_q <= prot_d;
    end
  end

  assign erase_req_out                = req_q;
  assign erase_go_out                 = go_q;
  assign busy_out                     = busy_q;
  assign erase_program_error_flag_out = epe_q;
  assign protect_active_out           = prot_q;

  // ==========================================================
  // Assertions
  a_page_req_addr: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    launch && dec_page_op |=> go_q && req_q.first_page == $past(dec_page)
      && req_q.page_count == SFE_PAGE_COUNT_ONE)
    else $error("page erase request wrong");
  a_busy_follows_go: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    launch |=> busy_out [*2])
    else $error("busy not held after erase start");
  a_epe_sticky: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    busy_q && erase_fail_in |=> epe_q)
    else $error("error flag not set on erase failure");
  a_block_aligned: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    launch && dec_block_op |=> req_q.first_page[2:0] == 3'h0
      && req_q.page_count == SFE_BLOCK_PAGES
      && req_q.first_page[10:3] == $past(dec_page[10:3]))
    else $error("block request not eight aligned pages");
  a_sector_single: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    launch && dec_sector_op |=> go_q ##1 !go_q)
    else $error("sector erase issued more than one request");
  a_sector_decode: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    launch && dec_sector_op && dec_page[10:8] != 3'h0
      |=> req_q.first_page[10:8] == $past(dec_page[10:8])
      && req_q.page_count == SFE_SECTOR_PAGES)
    else $error("large sector decode wrong");
  a_chip_guard: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_q == SFE_ST_CHIP_WALK && guard[step_q] |=> !go_q)
    else $error("guarded sector erased by chip erase");
  a_chip_walk_len: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_q == SFE_ST_IDLE && launch_any && dec_chip
      |=> (state_q == SFE_ST_CHIP_WALK) [*8] ##1 state_q == SFE_ST_CHIP_WALK
      ##1 state_q == SFE_ST_WAIT)
    else $error("chip erase walk length wrong");
  a_wp_deferred: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $past(busy_q) |-> $stable(protect_active_out))
    else $error("protection changed during erase");
  a_short_dropped: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cs_rise && !dec_full && state_q == SFE_ST_IDLE |=> !go_q && !busy_out)
    else $error("short command started an erase");
  c_page_erase: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    launch && dec_page_op);
  c_sector_0b: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    launch && dec_sector_op && dec_slot == 4'h1);
  c_chip_skip: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_q == SFE_ST_CHIP_WALK && guard[step_q]);
  c_erase_fail: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    busy_q && erase_fail_in);

endmodule : sfe_erase_seq
`default_nettype wire

/* sfe_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Host side of the serial link, mode 0: the link clock idles low
module sfe_spi_host (
  input  wire logic clk_in,
  output var  logic sck_out,
  output var  logic cs_b_out,
  output var  logic si_out
);
  // Idle link: deselected, clock standing still
  initial begin
    sck_out  = 1'b0;
    cs_b_out = 1'b1;
    si_out   = 1'b0;
  end

  // Four system clocks per level give the 400 ns link period
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask : half

  // Sends the top nbits of word MSB first, then extra filler ones
  task automatic frame(input logic [31:0] word, input int nbits, input int extra);
    int i;
    cs_b_out = 1'b0;
    for (i = 0; i < nbits + extra; i++) begin
      si_out = (i < nbits) ? word[31-i] : 1'b1;
      half();
      sck_out = 1'b1;
      half();
      sck_out = 1'b0;
    end
    half();
    cs_b_out = 1'b1;
    // Released data line shows the inverse so a stale bit never looks valid
    si_out = ~si_out;
    half();
  endtask : frame
endmodule : sfe_spi_host
`default_nettype wire

/* tb_sfe_erase_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_sfe_erase_seq;
  import sfe_pkg::*;
  // Short erase times keep the run brief
  localparam int PG_C = 20;
  localparam int BK_C = 30;
  localparam int SC_C = 40;
  localparam int CH_C = 50;

  typedef struct packed {
    logic        mode;
    logic [7:0]  op;
    logic [10:0] page;
    logic [10:0] first;
    logic [11:0] cnt;
    int          bsy;
  } sfe_row_s;

  logic      clk_sys_in;
  logic      rst_b_in;
  logic      sck;
  logic      cs_b;
  logic      si;
  logic      wp_b_in;
  logic      page_256_in;
  logic      erase_fail_in;
  logic [8:0] prot;
  logic [8:0] lock;
  sfe_req_s  req;
  logic      go;
  logic      busy;
  logic      erase_program_error_flag;
  logic      pact;
  int        num_errors;
  int        checked;
  int        bcnt;
  int        n;
  int        j;
  logic [23:0] addr;
  sfe_req_s  gos[$];
  sfe_row_s  rows[8];

  sfe_erase_seq #(
    .PAGE_ERASE_CYCLES   (PG_C),
    .BLOCK_ERASE_CYCLES  (BK_C),
    .SECTOR_ERASE_CYCLES (SC_C),
    .CHIP_ERASE_CYCLES   (CH_C)
  ) sfe_erase_seq_i (
    .clk_sys_in                   (clk_sys_in),
    .rst_b_in                     (rst_b_in),
    .sck_in                       (sck),
    .cs_b_in                      (cs_b),
    .si_in                        (si),
    .wp_b_in                      (wp_b_in),
    .page_256_in                  (page_256_in),
    .sector_protect_in            (prot),
    .sector_lock_in               (lock),
    .erase_fail_in                (erase_fail_in),
    .erase_req_out                (req),
    .erase_go_out                 (go),
    .busy_out                     (busy),
    .erase_program_error_flag_out (erase_program_error_flag),
    .protect_active_out           (pact)
  );

  sfe_spi_host sfe_spi_host_i (
    .clk_in   (clk_sys_in),
    .sck_out  (sck),
    .cs_b_out (cs_b),
    .si_out   (si)
  );

  // ============================================================
  // Clock and output monitor, sampled mid-cycle where values are settled
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  always @(negedge clk_sys_in) begin
    if (go === 1'b1) gos.push_back(req);
    if (busy === 1'b1) bcnt++;
  end

  // ============================================================
  // Checking and run control
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // One frame; with want set, waits for the launch and the end of busy
  task automatic run(input logic [31:0] word, input int nbits, input int extra, input bit want);
    int k;
    gos.delete();
    bcnt = 0;
    sfe_spi_host_i.frame(word, nbits, extra);
    for (k = 0; want && k < 400 && (gos.size() == 0 || busy !== 1'b0); k++) begin
      @(negedge clk_sys_in);
    end
    if (k == 400) begin
      num_errors++;
      test_done();
    end
    if (!want) repeat (20) @(negedge clk_sys_in);
  endtask : run

  // ============================================================
  // Main sequence
  initial begin
    num_errors = 0;
    checked = 0;
    rst_b_in = 1'b0;
    wp_b_in = 1'b1;
    page_256_in = 1'b0;
    erase_fail_in = 1'b0;
    prot = 9'h004;
    lock = 9'h020;
    // Busy stands for exactly the erase cycle count of the command
    rows[0] = '{1'b0, SFE_OP_PAGE_ERASE,   11'h7FF, 11'h7FF, 12'h001, PG_C};
    rows[1] = '{1'b1, SFE_OP_PAGE_ERASE,   11'h001, 11'h001, 12'h001, PG_C};
    rows[2] = '{1'b0, SFE_OP_BLOCK_ERASE,  11'h7FF, 11'h7F8, 12'h008, BK_C};
    rows[3] = '{1'b1, SFE_OP_BLOCK_ERASE,  11'h00D, 11'h008, 12'h008, BK_C};
    rows[4] = '{1'b0, SFE_OP_SECTOR_ERASE, 11'h3A5, 11'h300, 12'h100, SC_C};
    rows[5] = '{1'b1, SFE_OP_SECTOR_ERASE, 11'h700, 11'h700, 12'h100, SC_C};
    rows[6] = '{1'b0, SFE_OP_SECTOR_ERASE, 11'h00F, 11'h008, 12'h0F8, SC_C};
    rows[7] = '{1'b1, SFE_OP_SECTOR_ERASE, 11'h005, 11'h000, 12'h008, SC_C};
    repeat (8) @(negedge clk_sys_in);
    cmp({go, busy, erase_program_error_flag, pact, req}, 0);
    rst_b_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    // Table rows: dummy bits set to ones so a wrong field slice shows
    for (int i = 0; i < 8; i++) begin
      page_256_in = rows[i].mode;
      addr = rows[i].mode ? (24'hF8_00FF | {5'h00, rows[i].page, 8'h00})
                          : (24'hF0_01FF | {4'h0, rows[i].page, 9'h000});
      run({rows[i].op, addr}, 32, 0, 1'b1);
      cmp(gos.size(), 1);
      cmp(gos[0], {rows[i].first, rows[i].cnt});
      cmp(bcnt, rows[i].bsy);
      cmp(erase_program_error_flag, 0);
    end
    // Refused frames: unknown opcode, short frame, wrong chip sequence
    page_256_in = 1'b0;
    run(32'h0000_0000, 32, 0, 1'b0);
    cmp(gos.size(), 0);
    run(32'h8100_0200, 24, 0, 1'b0);
    cmp(gos.size(), 0);
    run(32'hC794_809B, 32, 0, 1'b0);
    cmp(gos.size(), 0);
    // Chip erase with filler bits, a one-cycle erase failure and write protect raised mid-erase
    fork
      run(SFE_CHIP_ERASE_SEQ, 32, 8, 1'b1);
      begin
        for (n = 0; n < 400 && busy !== 1'b1; n++) @(negedge clk_sys_in);
        cmp(busy, 1);
        wp_b_in = 1'b0;
        erase_fail_in = 1'b1;
        @(negedge clk_sys_in);
        erase_fail_in = 1'b0;
        repeat (20) @(negedge clk_sys_in);
        cmp(pact, 0);
      end
    join
    cmp(erase_program_error_flag, 1);
    cmp(gos.size(), 7);
    j = 0;
    for (int k = 0; k < 9; k++) begin
      if (k != 2 && k != 5) begin
        cmp(gos[j], (k == 0) ? {11'h000, 12'h008} : (k == 1) ? {11'h008, 12'h0F8}
                    : {3'(k - 1), 8'h00, 12'h100});
        j++;
      end
    end
    repeat (6) @(negedge clk_sys_in);
    cmp(pact, 1);
    wp_b_in = 1'b1;
    // A new erase clears the sticky error flag
    run(32'h8100_0000, 32, 0, 1'b1);
    cmp(erase_program_error_flag, 0);
    cmp(gos[0], {11'h000, 12'h001});
    // Reset after the last erase has ended clears every output
    rst_b_in = 1'b0;
    @(negedge clk_sys_in);
    cmp({go, busy, erase_program_error_flag, pact, req}, 0);
    test_done();
  end
endmodule : tb_sfe_erase_seq
`default_nettype wire
